// File: design/gdc_core.sv
// Function
// - Only edges of the selected count source (channel or reference clock) inside the open gate are forwarded to counting.
// - Forwarded count pulses last one full clock; no slivers reach the chain.
// - Eight cascaded BCD decades with latches and multiplexed digit output.
// - Eight-decade time base with synchronised gate open and close.
// - Sequencer makes inhibit, reset, gate, transfer, rate and digit address.
// - Count or module digits are decoded onto a nine-digit scanned display.
// - Function selector routes inputs to count chain, time base, or both.
// - Arming pulses go out to and come back from modules; module data accepted.
// - Function and time-base codes index a table giving a 32-bit set-up word.
// - The set-up table holds 4000 bits or more.
// - Extended input latches put the ninth, least digit on bus and display.
// - Without the extended module its strobing stops and digit nine blanks.
// - Time interval: start opens gate, stop closes it, clock is counted.
// - Time base divides in decade steps; its period sets gate length.
// - Transfer latches the count to the bus; counters clear after the cycle.
// - Detected external reference is selected, else the internal oscillator.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module gdc_core
(
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    // AXI4-Lite write address and data.
    input  wire logic [gdc_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                      s_awvalid,
    output logic                           s_awready,
    input  wire logic [31:0]               s_wdata,
    input  wire logic [3:0]                s_wstrb,
    input  wire logic                      s_wvalid,
    output logic                           s_wready,
    // AXI4-Lite write response.
    output logic      [1:0]                s_bresp,
    output logic                           s_bvalid,
    input  wire logic                      s_bready,
    // AXI4-Lite read.
    input  wire logic [gdc_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                      s_arvalid,
    output logic                           s_arready,
    output logic      [31:0]               s_rdata,
    output logic      [1:0]                s_rresp,
    output logic                           s_rvalid,
    input  wire logic                      s_rready,
    // Conditioned input pulses and module handshake.
    input  wire logic                      chan_a,
    input  wire logic                      chan_b,
    input  wire logic                      chan_c,
    input  wire logic                      start_in,
    input  wire logic                      stop_in,
    input  wire logic                      arm_in,
    input  wire logic                      ext_ref_present,
    input  wire logic                      ext_strobe,
    input  wire logic [3:0]                ext_digit,
    // Sequencer strobes and module arming.
    output logic                           arm_out,
    output logic                           inhibit_out,
    output logic                           reset_out,
    output logic                           xfer_out,
    output logic                           gate_out,
    output logic                           ref_sel_ext,
    // Scanned display.
    output gdc_pkg::gdc_disp_t             disp
);
    import gdc_pkg::*;

    // Set-up table: 128 entries of 32 bits, 4096 bits in all.
    function automatic gdc_setup_t setup_rom(input logic [3:0] fn, input logic [2:0] tb);
        gdc_setup_t s;
        s = '0;
        s.tb_exp = tb;
        s.dp_pos = {1'b0, tb};
        s.annunc = fn;
        case (fn)
            FN_FREQ_A: begin s.cnt_src = SRC_A;   s.tb_src = SRC_CLK; end
            FN_PERIOD: begin s.cnt_src = SRC_CLK; s.tb_src = SRC_A;   end
            FN_TI:     begin s.cnt_src = SRC_CLK; s.gate_mode = GM_SS; s.need_arm = 1'b1; end
            FN_RATIO:  begin s.cnt_src = SRC_B;   s.tb_src = SRC_A;   end
            FN_FREQ_C: begin s.cnt_src = SRC_C;   s.tb_src = SRC_CLK; s.ext_en = 1'b1; end
            FN_TOTAL:  begin s.cnt_src = SRC_A;   s.gate_mode = GM_OPEN; end
            default:   begin s.cnt_src = SRC_CLK; s.tb_src = SRC_CLK; end
        endcase
        return s;
    endfunction

    function automatic logic [6:0] seg7(input logic [3:0] d);
        logic [6:0] s;
        s = 7'h00;
        case (d)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            default: s = 7'h00;
        endcase
        return s;
    endfunction

    logic [8:0]        ctrl;
    logic [31:0]       hold_reg;
    gdc_setup_t        setup;
    gdc_state_t        state;
    logic [11:0]       pins_sync;
    logic [11:0]       pins_prev;
    logic              ev_a, ev_b, ev_c, ev_start, ev_stop, ev_arm, ev_estb;
    logic              tb_event, cnt_event, run;
    logic              count_window_flop, gate_sync, count_pulse;
    logic [NDEC*4-1:0] cnt_dig, tb_dig;
    logic [NDEC:0]     cnt_cy, tb_cy;
    logic              tb_done, open_now, close_now, chain_clr;
    logic              overflow, ovf_latch, arm_seen;
    logic [31:0]       count_latch;
    logic [3:0]        ext_latch;
    logic [31:0]       hold_cnt;
    logic [15:0]       scan_cnt;
    logic [3:0]        sel_digit;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_full, w_full;

    assign run   = ctrl[CTRL_RUN_BIT];
    assign setup = setup_rom(ctrl[CTRL_FUNC_LSB +: 4], ctrl[CTRL_TB_LSB +: 3]);

    // Pins pass two flip-flops before any logic reads them.
    gdc_sync #(.W(12)) u_pins (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in ({ext_digit, ext_strobe, ext_ref_present, arm_in, stop_in, start_in,
                    chan_c, chan_b, chan_a}),
        .sync_out (pins_sync)
    );

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pins_prev <= '0;
        else
            pins_prev <= pins_sync;
    end

    assign ev_a     = pins_sync[0] & ~pins_prev[0];
    assign ev_b     = pins_sync[1] & ~pins_prev[1];
    assign ev_c     = pins_sync[2] & ~pins_prev[2];
    assign ev_start = pins_sync[3] & ~pins_prev[3];
    assign ev_stop  = pins_sync[4] & ~pins_prev[4];
    assign ev_arm   = pins_sync[5] & ~pins_prev[5];
    assign ev_estb  = pins_sync[7] & ~pins_prev[7] & setup.ext_en;

    // Function selector: one source to the time base, one to the count chain.
    always_comb
    begin
        case (setup.tb_src)
            SRC_A:   tb_event = ev_a;
            SRC_B:   tb_event = ev_b;
            SRC_C:   tb_event = ev_c;
            default: tb_event = 1'b1;
        endcase
        case (setup.cnt_src)
            SRC_A:   cnt_event = ev_a;
            SRC_B:   cnt_event = ev_b;
            SRC_C:   cnt_event = ev_c;
            default: cnt_event = 1'b1;
        endcase
    end

    // Gate open and close conditions per gate mode.
    always_comb
    begin
        case (setup.gate_mode)
            GM_SS:   begin open_now = ev_start; close_now = ev_stop; end
            GM_OPEN: begin open_now = 1'b1;     close_now = ~run;    end
            default: begin open_now = tb_event; close_now = tb_done; end
        endcase
    end

    assign chain_clr = (state == ST_CLEAR) || (state == ST_HOLD);

    // Time base divider: carry tb_cy[k] marks 10^k events.
    assign tb_cy[0] = tb_event && count_window_flop && (setup.gate_mode == GM_TB);
    assign cnt_cy[0] = count_pulse;
    for (genvar k = 0; k < NDEC; k++)
    begin : g_dec
        gdc_decade u_tb (
            .mclk  (mclk),
            .rstn  (rstn),
            .clr   (chain_clr),
            .inc   (tb_cy[k]),
            .digit (tb_dig[k*4 +: 4]),
            .carry (tb_cy[k+1])
        );
        gdc_decade u_cnt (
            .mclk  (mclk),
            .rstn  (rstn),
            .clr   (chain_clr),
            .inc   (cnt_cy[k]),
            .digit (cnt_dig[k*4 +: 4]),
            .carry (cnt_cy[k+1])
        );
    end

    assign tb_done = (setup.tb_exp == 3'h0) ? tb_cy[0] : tb_cy[setup.tb_exp];

    // Main gate, its resynchronised copy and the full-width count pulse.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_window_flop <= 1'b0;
            gate_sync         <= 1'b0;
            count_pulse       <= 1'b0;
        end
        else
        begin
            if (count_window_flop && close_now)
                count_window_flop <= 1'b0;
            else if (state == ST_ARM && (!setup.need_arm || arm_seen) && open_now)
                count_window_flop <= 1'b1;
            gate_sync   <= count_window_flop;
            count_pulse <= gate_sync && cnt_event;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            overflow <= 1'b0;
        else if (cnt_cy[NDEC])
            overflow <= 1'b1;
        else if (chain_clr)
            overflow <= 1'b0;
    end

    // Display-cycle sequencer.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state    <= ST_IDLE;
            hold_cnt <= ZERO32;
            arm_seen <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:  if (run) state <= ST_CLEAR;
                ST_CLEAR:
                begin
                    arm_seen <= 1'b0;
                    state    <= ST_ARM;
                end
                ST_ARM:
                begin
                    if (ev_arm)
                        arm_seen <= 1'b1;
                    if (count_window_flop)
                        state <= ST_GATE;
                    else if (!run)
                        state <= ST_IDLE;
                end
                ST_GATE:  if (!count_window_flop) state <= ST_DRAIN;
                ST_DRAIN: if (!gate_sync && !count_pulse) state <= ST_XFER;
                ST_XFER:
                begin
                    hold_cnt <= hold_reg;
                    state    <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    if (hold_cnt != ZERO32)
                        hold_cnt <= hold_cnt - 32'h0000_0001;
                    else
                        state <= run ? ST_CLEAR : ST_IDLE;
                end
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // Strobes, transfer latches and reference selection.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            arm_out     <= 1'b0;
            inhibit_out <= 1'b1;
            reset_out   <= 1'b0;
            xfer_out    <= 1'b0;
            gate_out    <= 1'b0;
            ref_sel_ext <= 1'b0;
            count_latch <= ZERO32;
            ovf_latch   <= 1'b0;
            ext_latch   <= BCD_ZERO;
        end
        else
        begin
            arm_out     <= (state == ST_CLEAR) && setup.need_arm;
            inhibit_out <= (state != ST_ARM) && (state != ST_GATE);
            reset_out   <= chain_clr;
            xfer_out    <= (state == ST_XFER);
            gate_out    <= count_window_flop;
            ref_sel_ext <= pins_sync[6];
            if (state == ST_XFER)
            begin
                count_latch <= cnt_dig;
                ovf_latch   <= overflow;
            end
            if (ev_estb)
                ext_latch <= pins_sync[11:8];
        end
    end

    // Digit scan: address 0 is the ninth, least digit from the module.
    always_comb
    begin
        if (disp.addr == BCD_ZERO)
            sel_digit = ext_latch;
        else
            sel_digit = count_latch[(disp.addr - BCD_ONE) * 4 +: 4];
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            scan_cnt <= '0;
            disp     <= '0;
        end
        else
        begin
            scan_cnt <= (scan_cnt == SCAN_LAST) ? '0 : scan_cnt + 16'h0001;
            if (scan_cnt == SCAN_LAST)
                disp.addr <= (disp.addr == LAST_ADDR) ? BCD_ZERO : disp.addr + BCD_ONE;
            disp.data  <= sel_digit;
            disp.blank <= (disp.addr == BCD_ZERO) && !setup.ext_en;
            disp.seg   <= ((disp.addr == BCD_ZERO) && !setup.ext_en) ? 7'h00 : seg7(sel_digit);
            disp.dp    <= (disp.addr == setup.dp_pos) && (disp.addr != BCD_ZERO);
        end
    end

    // AXI4-Lite slave: address and data may arrive in either order.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= '0;
            w_data    <= ZERO32;
            w_strb    <= '0;
            ctrl      <= CTRL_RST;
            hold_reg  <= HOLD_RST;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_addr   <= s_awaddr;
                aw_full   <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_data   <= s_wdata;
                w_strb   <= s_wstrb;
                w_full   <= 1'b1;
                s_wready <= 1'b0;
            end
            if (aw_full && w_full && !s_bvalid)
            begin
                aw_full  <= 1'b0;
                w_full   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= RESP_OKAY;
                if (aw_addr == ADDR_CTRL)
                begin
                    if (w_strb[0])
                        ctrl[7:0] <= w_data[7:0];
                    if (w_strb[1])
                        ctrl[8] <= w_data[CTRL_RUN_BIT];
                end
                else if (aw_addr == ADDR_HOLD)
                begin
                    for (int b = 0; b < 4; b++)
                        if (w_strb[b])
                            hold_reg[b*8 +: 8] <= w_data[b*8 +: 8];
                end
                else if (aw_addr != ADDR_STATUS && aw_addr != ADDR_COUNT &&
                         aw_addr != ADDR_SETUP && aw_addr != ADDR_EXTD)
                    s_bresp <= RESP_SLVERR;
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= ZERO32;
            s_rresp   <= RESP_OKAY;
        end
        else if (s_arvalid && s_arready)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rresp   <= RESP_OKAY;
            if (s_araddr == ADDR_CTRL)
                s_rdata <= {23'h00_0000, ctrl};
            else if (s_araddr == ADDR_STATUS)
                s_rdata <= {21'h00_0000, ovf_latch, ref_sel_ext, count_window_flop, 1'b0, state};
            else if (s_araddr == ADDR_COUNT)
                s_rdata <= count_latch;
            else if (s_araddr == ADDR_SETUP)
                s_rdata <= setup;
            else if (s_araddr == ADDR_HOLD)
                s_rdata <= hold_reg;
            else if (s_araddr == ADDR_EXTD)
                s_rdata <= {27'h000_0000, setup.ext_en, ext_latch};
            else
            begin
                s_rdata <= ZERO32;
                s_rresp <= RESP_SLVERR;
            end
        end
        else if (s_rvalid && s_rready)
        begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end
endmodule

// File: design/gdc_decade.sv
`timescale 1ns/100ps
module gdc_decade
    import gdc_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Count control.
    input  wire logic       clr,
    input  wire logic       inc,
    // Digit and ripple carry.
    output logic      [3:0] digit,
    output logic            carry
);
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            digit <= BCD_ZERO;
        else if (clr)
            digit <= BCD_ZERO;
        else if (inc)
            digit <= (digit == BCD_MAX) ? BCD_ZERO : digit + BCD_ONE;
    end

    assign carry = inc && (digit == BCD_MAX);
endmodule

// File: design/gdc_sync.sv
`timescale 1ns/100ps
module gdc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// File: shared/gdc_pkg.sv
package gdc_pkg;

    // Clock and timing.
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned SCAN_US     = 100;
    localparam int unsigned SCAN_CYC    = SCAN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOLD_MS     = 1;
    localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1_000);

    // Bus geometry and register map.
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_COUNT  = 8'h08;
    localparam logic [7:0]  ADDR_SETUP  = 8'h0C;
    localparam logic [7:0]  ADDR_HOLD   = 8'h10;
    localparam logic [7:0]  ADDR_EXTD   = 8'h14;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] ZERO32      = 32'h0000_0000;
    localparam logic [31:0] HOLD_RST    = 32'(HOLD_CYC);

    // Control register fields.
    localparam int          CTRL_FUNC_LSB = 0;
    localparam int          CTRL_TB_LSB   = 4;
    localparam int          CTRL_RUN_BIT  = 8;
    localparam logic [8:0]  CTRL_RST      = 9'h000;

    // Counting chain.
    localparam int          NDEC      = 8;
    localparam int          NDIG      = 9;
    localparam logic [3:0]  BCD_ZERO  = 4'h0;
    localparam logic [3:0]  BCD_ONE   = 4'h1;
    localparam logic [3:0]  BCD_MAX   = 4'h9;
    localparam logic [3:0]  LAST_ADDR = 4'h8;
    localparam logic [15:0] SCAN_LAST = 16'(SCAN_CYC - 1);

    // Function codes.
    localparam logic [3:0]  FN_FREQ_A = 4'h0;
    localparam logic [3:0]  FN_PERIOD = 4'h1;
    localparam logic [3:0]  FN_TI     = 4'h2;
    localparam logic [3:0]  FN_RATIO  = 4'h3;
    localparam logic [3:0]  FN_CHECK  = 4'h4;
    localparam logic [3:0]  FN_FREQ_C = 4'h5;
    localparam logic [3:0]  FN_TOTAL  = 4'h6;

    // Signal sources and gate modes.
    localparam logic [1:0]  SRC_CLK   = 2'h0;
    localparam logic [1:0]  SRC_A     = 2'h1;
    localparam logic [1:0]  SRC_B     = 2'h2;
    localparam logic [1:0]  SRC_C     = 2'h3;
    localparam logic [1:0]  GM_TB     = 2'h0;
    localparam logic [1:0]  GM_SS     = 2'h1;
    localparam logic [1:0]  GM_OPEN   = 2'h2;

    typedef struct packed {
        logic [12:0] spare;
        logic [3:0]  annunc;
        logic [3:0]  dp_pos;
        logic        ext_en;
        logic        need_arm;
        logic [2:0]  tb_exp;
        logic [1:0]  gate_mode;
        logic [1:0]  tb_src;
        logic [1:0]  cnt_src;
    } gdc_setup_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] data;
        logic       blank;
        logic [6:0] seg;
        logic       dp;
    } gdc_disp_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_CLEAR = 7'b000_0010,
        ST_ARM   = 7'b000_0100,
        ST_GATE  = 7'b000_1000,
        ST_DRAIN = 7'b001_0000,
        ST_XFER  = 7'b010_0000,
        ST_HOLD  = 7'b100_0000
    } gdc_state_t;

endpackage

// File: verif/gdc_core_bench.sv
`timescale 1ns/100ps
module gdc_core_bench;
    import gdc_pkg::*;
    logic        mclk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, arm_in, ext_strobe;
    logic        start_in, stop_in, ext_ref_present, arm_out, inhibit_out, reset_out;
    logic        xfer_out, gate_out, ref_sel_ext;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0]  s_wstrb, ext_digit;
    logic [1:0]  s_bresp, s_rresp;
    logic [2:0]  chans;
    gdc_disp_t   disp;
    int          fails, num_checks;
    localparam logic [7:0]  RA [6] = '{ADDR_CTRL, ADDR_STATUS, ADDR_COUNT, ADDR_HOLD, ADDR_EXTD,
                                       8'h18};
    localparam logic [31:0] RD [6] = '{ZERO32, 32'h0000_0001, ZERO32, HOLD_RST, ZERO32, ZERO32};
    localparam logic [1:0]  RR [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY,
                                       RESP_SLVERR};
    gdc_core dut_u (.mclk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .chan_a(chans[0]),
        .chan_b(chans[1]), .chan_c(chans[2]), .start_in, .stop_in, .arm_in, .ext_ref_present,
        .ext_strobe, .ext_digit, .arm_out, .inhibit_out, .reset_out, .xfer_out, .gate_out,
        .ref_sel_ext, .disp);
    gdc_modl modl_u (.mclk, .rstn, .arm_out, .chans, .arm_in, .ext_strobe, .ext_digit);
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic cmp(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_awaddr  <= a;
        s_wdata   <= v;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end while (!s_bvalid);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        cmp(d, e);
        cmp({30'h0, s_rresp}, {30'h0, er});
    endtask
    task automatic meas(input logic [3:0] fn, input logic [2:0] tb);
        wr(ADDR_CTRL, {23'h0, 2'h2, tb, fn});
        do @(posedge mclk); while (xfer_out !== 1'b1);
        wr(ADDR_CTRL, {25'h0, tb, fn});
    endtask
    task automatic digit9(input logic [31:0] e, m);
        do @(posedge mclk); while (disp.addr !== LAST_ADDR);
        do @(posedge mclk); while (disp.addr !== 4'h0);
        repeat (2) @(posedge mclk);
        cmp({27'h0, disp.blank, disp.data} & m, e);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 6'h00;
        {start_in, stop_in, ext_ref_present} <= 3'h0;
        {s_awaddr, s_araddr, s_wdata} <= 48'h0;
        s_wstrb <= 4'hF;
        repeat (8) @(posedge mclk);
        cmp({s_awready, s_wready, s_arready, inhibit_out, xfer_out, gate_out}, 6'h3C);
        rstn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 6; i++)
            rdc(RA[i], RD[i], RR[i]);
        ext_ref_present <= 1'b1;
        wr(ADDR_HOLD, 32'h0000_0004);
        for (int k = 0; k < 4; k++)
        begin
            meas(FN_CHECK, 3'(k));
            rdc(ADDR_COUNT, 32'h0000_0001 << (4 * k), RESP_OKAY);
        end
        fork
            meas(FN_TI, 3'h0);
            begin
                do @(posedge mclk); while (arm_out !== 1'b1);
                repeat (20) @(posedge mclk);
                start_in <= 1'b1;
                repeat (25) @(posedge mclk);
                stop_in <= 1'b1;
            end
        join
        rdc(ADDR_COUNT, 32'h0000_0025, RESP_OKAY);
        cmp({31'h0, ref_sel_ext}, 32'h0000_0001);
        meas(FN_FREQ_C, 3'h1);
        digit9(32'h0000_0007, 32'h0000_001F);
        rdc(ADDR_EXTD, 32'h0000_0017, RESP_OKAY);
        wr(ADDR_CTRL, {28'h0, FN_FREQ_A});
        digit9(32'h0000_0010, 32'h0000_0010);
        rdc(ADDR_EXTD, 32'h0000_0007, RESP_OKAY);
        cmp(d & 32'h0000_0010, ZERO32);
        conclude();
    end
    initial
    begin
        #6000000;
        fails++;
        conclude();
    end
endmodule

// File: verif/gdc_core_chk.sv
`timescale 1ns/100ps
module gdc_chk (
    // Clock and reset.
    input wire logic               mclk,
    input wire logic               rstn,
    // Bus handshake.
    input wire logic               s_arready,
    input wire logic               s_bvalid,
    input wire logic               s_bready,
    input wire logic               s_rvalid,
    input wire logic               s_rready,
    input wire logic [31:0]        s_rdata,
    // Sequencer and display.
    input wire logic               arm_out,
    input wire logic               inhibit_out,
    input wire logic               reset_out,
    input wire logic               xfer_out,
    input wire logic               gate_out,
    input wire gdc_pkg::gdc_disp_t disp
);
    import gdc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_b_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("bvalid dropped");
    chk_rd_stable: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("rdata unstable");
    chk_ar_refused: assert property (s_rvalid |-> !s_arready)
        else $error("arready while busy");
    chk_xfer_pulse: assert property (xfer_out |=> !xfer_out)
        else $error("long transfer strobe");
    chk_xfer_clear: assert property (xfer_out |-> ##[0:2] reset_out)
        else $error("no clear");
    chk_arm_pulse: assert property (arm_out |=> !arm_out)
        else $error("long arming pulse");
    chk_gate_inhibit: assert property ($rose(gate_out) |-> !inhibit_out)
        else $error("gate while inhibited");
    chk_scan_range: assert property (disp.addr <= LAST_ADDR)
        else $error("address out of range");
    chk_scan_hold: assert property (!$stable(disp.addr) |=> $stable(disp.addr) [*8])
        else $error("address held too briefly");
    chk_scan_step: assert property (!$stable(disp.addr) |-> disp.addr ==
        (($past(disp.addr) == LAST_ADDR) ? 4'h0 : $past(disp.addr) + 4'h1))
        else $error("address skipped");
endmodule
bind gdc_core gdc_chk chk_u (.mclk, .rstn, .s_arready, .s_bvalid, .s_bready, .s_rvalid,
    .s_rready, .s_rdata, .arm_out, .inhibit_out, .reset_out, .xfer_out, .gate_out, .disp);

// File: verif/gdc_modl.sv
`timescale 1ns/100ps
module gdc_modl #(
    parameter logic [3:0] DIGIT = 4'h7
) (
    // Clock, reset and arming request.
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       arm_out,
    // Conditioned pulses, arming return and extended digit.
    output logic      [2:0] chans,
    output logic            arm_in,
    output logic            ext_strobe,
    output logic      [3:0] ext_digit
);
    logic [4:0] tick;
    logic [2:0] arm_dly;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick    <= 5'h00;
            arm_dly <= 3'h0;
        end
        else
        begin
            tick    <= tick + 5'h01;
            arm_dly <= {arm_dly[1:0], arm_out};
        end
    end
    assign chans      = tick[3:1];
    assign arm_in     = arm_dly[2] | arm_dly[1];
    assign ext_strobe = tick[4];
    assign ext_digit  = DIGIT;
endmodule
